// *** src/ext_bus_pkg.sv ***
package ext_bus_pkg;
   // Bus widths
   localparam int ADDR_W = 16;
   localparam int DATA_W = 16;
   // Reset pulse must span this many processor cycles
   localparam int RESET_MIN_CYCLES = 5;
   // Clock period and quarter-cycle drive delay in ns
   localparam int CLK_PERIOD_NS = 10;
   localparam int DRIVE_DELAY_NS = 3;
   // Least time rounds up to whole cycles, never below one
   localparam int DRIVE_DELAY_RAW = (DRIVE_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int DRIVE_DELAY_CYC = (DRIVE_DELAY_RAW < 1) ? 1 : DRIVE_DELAY_RAW;
   // Reset values
   localparam logic [15:0] ADDR_RESET = 16'h0000;
   localparam logic [15:0] DATA_RESET = 16'h0000;
   // Access kinds
   typedef enum logic [2:0] {
      ACC_MEM_READ = 3'b000,
      ACC_MEM_WRITE = 3'b001,
      ACC_IO_READ = 3'b010,
      ACC_IO_WRITE = 3'b011,
      ACC_NONE = 3'b100
   } access_t;
   // Bus cycle phases
   typedef enum logic [1:0] {
      PH_IDLE = 2'b00,
      PH_STROBE = 2'b01,
      PH_DRIVE = 2'b10,
      PH_END = 2'b11
   } phase_t;
endpackage

// *** src/reset_sync_if.sv ***
`timescale 1ns/1ps
interface reset_sync_if;
   logic reset_raw_n;
   logic reset_sync_n;
   modport sync (input reset_raw_n, output reset_sync_n);
   modport user (output reset_raw_n, input reset_sync_n);
endinterface

// *** src/reset_synchroniser.sv ***
`timescale 1ns/1ps
module reset_synchroniser (
   input wire logic clk_sys,
   reset_sync_if.sync rs
);
   logic stage1_reg;
   logic stage2_reg;

   // Two flip-flops bring the pin level into the clock domain
   always_ff @(posedge clk_sys) begin
      stage1_reg <= rs.reset_raw_n; // see R5
      stage2_reg <= stage1_reg;
   end

   assign rs.reset_sync_n = stage2_reg;
endmodule

// *** src/dsp_ext_bus_reset_control.sv ***
`timescale 1ns/1ps
// What this block does
// R1: During reset all four strobes stay high and data bus floats.
// R2: After reset falls, address outputs and program counter clear to zero.
// R3: Reset must be held low at least five processor cycles.
// R4: After reset rises, execution restarts from address zero after one cycle.
// R5: Reset input passes a two-stage synchroniser; latency varies with edge.
// R6: Never more than one of the four strobes low at once.
// R7: Reset during a write may leave the write address invalid.
// R8: Outside logic ties write strobes straight to memory write inputs.
// R9: Outside data-hold latches must release the bus before next fetch.
// R10: Outside decode delay plus hold must not exceed strobe-to-drive delay.
// R11: Write data drive starts no earlier than a quarter cycle after strobe.
// R12: Strobes are active low and return high at each bus cycle end.
module dsp_ext_bus_reset_control #(
   parameter int ADDR_W = ext_bus_pkg::ADDR_W,
   parameter int DATA_W = ext_bus_pkg::DATA_W
) (
   input wire logic clk_sys,
   input wire logic resetn,
   input wire logic reset_in_n,
   input wire logic req_valid,
   output logic req_ready,
   input wire logic [2:0] req_kind,
   input wire logic [ADDR_W-1:0] req_addr,
   input wire logic [DATA_W-1:0] req_wdata,
   output logic rsp_valid,
   output logic [DATA_W-1:0] rsp_rdata,
   output logic [ADDR_W-1:0] address_outputs,
   output logic [ADDR_W-1:0] program_counter,
   output logic run,
   output logic processor_clock_out,
   output logic mem_read_strobe_n,
   output logic mem_write_strobe_n,
   output logic io_read_strobe_n,
   output logic io_write_strobe_n,
   input wire logic [DATA_W-1:0] data_in,
   output logic [DATA_W-1:0] data_out,
   output logic data_oe_n
);
   reset_sync_if rs_if ();
   logic core_rst_n;
   logic in_reset_reg;
   logic in_reset_next;
   logic run_reg;
   logic run_next;
   ext_bus_pkg::phase_t phase_reg;
   ext_bus_pkg::phase_t phase_next;
   ext_bus_pkg::access_t kind_reg;
   logic [ADDR_W-1:0] addr_reg;
   logic [ADDR_W-1:0] pc_reg;
   logic [DATA_W-1:0] wdata_reg;
   logic [DATA_W-1:0] rdata_reg;
   logic rsp_reg;
   logic clk_div_reg;
   logic [3:0] drive_cnt_reg;
   logic is_write;
   logic is_read;
   logic start_access;
   logic drive_done;
   logic strobe_on;
   logic abort_now;
   logic fetch_take;
   logic capture_read;
   logic [3:0] strobe_n_vec;
   logic [3:0] drive_cnt_next;
   ext_bus_pkg::access_t kind_next;
   logic [ADDR_W-1:0] addr_next;
   logic [ADDR_W-1:0] pc_next;
   logic [DATA_W-1:0] wdata_next;
   logic [DATA_W-1:0] rdata_next;
   logic rsp_next;

   assign rs_if.reset_raw_n = reset_in_n;
   reset_synchroniser u_sync (
      .clk_sys(clk_sys),
      .rs(rs_if.sync)
   );
   assign core_rst_n = rs_if.reset_sync_n; // see R5

   // Access decode
   assign is_write = (kind_reg == ext_bus_pkg::ACC_MEM_WRITE) || (kind_reg == ext_bus_pkg::ACC_IO_WRITE);
   assign is_read = (kind_reg == ext_bus_pkg::ACC_MEM_READ) || (kind_reg == ext_bus_pkg::ACC_IO_READ);
   assign start_access = req_valid && req_ready;
   assign req_ready = run_reg && (phase_reg == ext_bus_pkg::PH_IDLE) && core_rst_n;
   assign drive_done = (drive_cnt_reg == 4'(ext_bus_pkg::DRIVE_DELAY_CYC));
   assign strobe_on = !in_reset_reg && (phase_reg == ext_bus_pkg::PH_STROBE || phase_reg == ext_bus_pkg::PH_DRIVE);
   // A synchronised reset cuts any bus cycle short at the next edge
   assign abort_now = in_reset_reg || !core_rst_n; // see R7

   // Strobes: one decoded kind at a time, high in reset and at cycle end; kind codes 0 to 3 follow port order
   for (genvar i = 0; i < 4; i++) begin : g_strobe
      assign strobe_n_vec[i] = !(strobe_on && kind_reg == ext_bus_pkg::access_t'(3'(i))); // see R1 see R6 see R12
   end
   assign mem_read_strobe_n = strobe_n_vec[0];
   assign mem_write_strobe_n = strobe_n_vec[1];
   assign io_read_strobe_n = strobe_n_vec[2];
   assign io_write_strobe_n = strobe_n_vec[3];

   // Data bus drives only in the late write phase, never in reset
   assign data_oe_n = !(!in_reset_reg && is_write && phase_reg == ext_bus_pkg::PH_DRIVE); // see R1 see R11
   assign data_out = wdata_reg;
   assign address_outputs = addr_reg;
   assign program_counter = pc_reg;
   assign run = run_reg;
   assign processor_clock_out = clk_div_reg;
   assign rsp_valid = rsp_reg;
   assign rsp_rdata = rdata_reg;

   // Reset state and restart one full cycle after release
   assign in_reset_next = !core_rst_n;
   assign run_next = core_rst_n && !in_reset_reg; // see R4

   // Bus cycle sequencing
   always_comb begin
      phase_next = phase_reg;
      unique case (phase_reg)
         ext_bus_pkg::PH_IDLE: begin
            if (start_access) begin
               phase_next = ext_bus_pkg::PH_STROBE;
            end
         end
         ext_bus_pkg::PH_STROBE: begin
            if (drive_done) begin
               phase_next = ext_bus_pkg::PH_DRIVE; // see R11
            end
         end
         ext_bus_pkg::PH_DRIVE: begin
            phase_next = ext_bus_pkg::PH_END;
         end
         ext_bus_pkg::PH_END: begin
            phase_next = ext_bus_pkg::PH_IDLE; // see R12
         end
      endcase
   end

   // Next values of the access registers; an aborted cycle gives no finish pulse
   assign kind_next = abort_now ? ext_bus_pkg::ACC_NONE :
      start_access ? ext_bus_pkg::access_t'(req_kind) :
      (phase_reg == ext_bus_pkg::PH_END) ? ext_bus_pkg::ACC_NONE : kind_reg;
   assign drive_cnt_next = (abort_now || phase_reg != ext_bus_pkg::PH_STROBE) ? 4'h0 : drive_cnt_reg + 4'h1;
   assign fetch_take = start_access && (ext_bus_pkg::access_t'(req_kind) == ext_bus_pkg::ACC_MEM_READ);
   assign addr_next = in_reset_reg ? ADDR_W'(ext_bus_pkg::ADDR_RESET) : // see R2
      start_access ? req_addr : addr_reg;
   assign pc_next = in_reset_reg ? ADDR_W'(ext_bus_pkg::ADDR_RESET) : // see R2 see R4
      fetch_take ? pc_reg + ADDR_W'(1) : pc_reg;
   assign wdata_next = start_access ? req_wdata : wdata_reg;
   assign capture_read = !abort_now && is_read && (phase_reg == ext_bus_pkg::PH_DRIVE);
   assign rdata_next = capture_read ? data_in : rdata_reg;
   assign rsp_next = !abort_now && (phase_reg == ext_bus_pkg::PH_DRIVE); // see R7

   // In-reset flag follows the synchronised pin one edge later
   always_ff @(posedge clk_sys) begin
      if (!resetn) begin
         in_reset_reg <= 1'b1;
      end else begin
         in_reset_reg <= in_reset_next;
      end
   end

   // Execution flag, raised one full cycle after the in-reset flag drops
   always_ff @(posedge clk_sys) begin
      if (!resetn) begin
         run_reg <= 1'b0;
      end else begin
         run_reg <= run_next; // see R4
      end
   end

   // Processor clock out at half the system clock
   always_ff @(posedge clk_sys) begin
      if (!resetn) begin
         clk_div_reg <= 1'b0;
      end else begin
         clk_div_reg <= !clk_div_reg;
      end
   end

   // Bus cycle phase; a synchronised reset returns it to idle
   always_ff @(posedge clk_sys) begin
      if (!resetn) begin
         phase_reg <= ext_bus_pkg::PH_IDLE;
      end else begin
         phase_reg <= abort_now ? ext_bus_pkg::PH_IDLE : phase_next; // see R7
      end
   end

   // Kind of the access in progress
   always_ff @(posedge clk_sys) begin
      if (!resetn) begin
         kind_reg <= ext_bus_pkg::ACC_NONE;
      end else begin
         kind_reg <= kind_next;
      end
   end

   // Counts strobe cycles before the write data may drive
   always_ff @(posedge clk_sys) begin
      if (!resetn) begin
         drive_cnt_reg <= 4'h0;
      end else begin
         drive_cnt_reg <= drive_cnt_next; // see R11
      end
   end

   // Address outputs
   always_ff @(posedge clk_sys) begin
      if (!resetn) begin
         addr_reg <= ADDR_W'(ext_bus_pkg::ADDR_RESET);
      end else begin
         addr_reg <= addr_next; // see R2
      end
   end

   // Program counter, one step per accepted memory read
   always_ff @(posedge clk_sys) begin
      if (!resetn) begin
         pc_reg <= ADDR_W'(ext_bus_pkg::ADDR_RESET);
      end else begin
         pc_reg <= pc_next; // see R2 see R4
      end
   end

   // Write data held for the drive phase
   always_ff @(posedge clk_sys) begin
      if (!resetn) begin
         wdata_reg <= DATA_W'(ext_bus_pkg::DATA_RESET);
      end else begin
         wdata_reg <= wdata_next;
      end
   end

   // Read data taken in the last strobe cycle
   always_ff @(posedge clk_sys) begin
      if (!resetn) begin
         rdata_reg <= DATA_W'(ext_bus_pkg::DATA_RESET);
      end else begin
         rdata_reg <= rdata_next;
      end
   end

   // One-cycle finish pulse
   always_ff @(posedge clk_sys) begin
      if (!resetn) begin
         rsp_reg <= 1'b0;
      end else begin
         rsp_reg <= rsp_next;
      end
   end
endmodule

// *** test/ext_bus_props.sv ***
`timescale 1ns/1ps
module ext_bus_props (
   input wire logic clk_sys,
   input wire logic resetn,
   input wire logic reset_in_n,
   input wire logic req_valid,
   input wire logic req_ready,
   input wire logic rsp_valid,
   input wire logic [15:0] address_outputs,
   input wire logic [15:0] program_counter,
   input wire logic run,
   input wire logic mem_read_strobe_n,
   input wire logic mem_write_strobe_n,
   input wire logic io_read_strobe_n,
   input wire logic io_write_strobe_n,
   input wire logic data_oe_n
);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!resetn);
   // Strobes gathered, a low bit is an active strobe
   wire [3:0] strb_n = {mem_read_strobe_n, mem_write_strobe_n, io_read_strobe_n, io_write_strobe_n};
   // Access steps: take, three strobe cycles, release with the answer
   sequence s_take; req_valid && req_ready; endsequence
   sequence s_access; (strb_n != 4'hf) [*3] ##1 (strb_n == 4'hf && rsp_valid); endsequence
   a_one_strobe: assert property ($onehot0(~strb_n)) else $error("two strobes low");
   a_reset_idle: assert property (!reset_in_n [*4] |-> strb_n == 4'hf && data_oe_n)
      else $error("bus busy in reset");
   a_reset_clear: assert property (!reset_in_n [*5] |-> address_outputs == 16'h0 && program_counter == 16'h0)
      else $error("address not cleared");
   a_sync_delay: assert property ($fell(reset_in_n) |-> ##[2:4] (address_outputs == 16'h0))
      else $error("reset latency off");
   a_run_resume: assert property ($rose(reset_in_n) |-> !run ##[1:4] (run && program_counter == 16'h0))
      else $error("no restart at zero");
   a_cycle_shape: assert property (disable iff (!resetn || !reset_in_n) s_take |=> s_access)
      else $error("bad strobe cycle");
   a_ready_busy: assert property (s_take |=> !req_ready [*4])
      else $error("ready while busy");
   a_write_drive: assert property ($fell(data_oe_n) |-> !$past(mem_write_strobe_n && io_write_strobe_n))
      else $error("data driven early");
   a_abort_quiet: assert property (!reset_in_n [*4] |-> !rsp_valid)
      else $error("finish pulse in reset");
endmodule
bind dsp_ext_bus_reset_control ext_bus_props u_ext_bus_props (
   .clk_sys(clk_sys),
   .resetn(resetn),
   .reset_in_n(reset_in_n),
   .req_valid(req_valid),
   .req_ready(req_ready),
   .rsp_valid(rsp_valid),
   .address_outputs(address_outputs),
   .program_counter(program_counter),
   .run(run),
   .mem_read_strobe_n(mem_read_strobe_n),
   .mem_write_strobe_n(mem_write_strobe_n),
   .io_read_strobe_n(io_read_strobe_n),
   .io_write_strobe_n(io_write_strobe_n),
   .data_oe_n(data_oe_n)
);

// *** test/sram_partner.sv ***
`timescale 1ns/1ps
module sram_partner (
   input wire logic clk_sys,
   input wire logic mem_read_strobe_n,
   input wire logic mem_write_strobe_n,
   input wire logic io_read_strobe_n,
   input wire logic io_write_strobe_n,
   input wire logic [15:0] address_outputs,
   input wire logic [15:0] data_out,
   input wire logic data_oe_n,
   output logic [15:0] data_in
);
   logic [15:0] mem [32];
   wire [4:0] idx = {!io_write_strobe_n || !io_read_strobe_n, address_outputs[3:0]};
   // Write strobes reach the write inputs with no decode
   // A floating data bus reads back as the inverse of the held write word on data_out
   wire [15:0] bus_word = data_oe_n ? ~data_out : data_out;
   always @(posedge clk_sys) if (!mem_write_strobe_n || !io_write_strobe_n) mem[idx] <= bus_word;
   // Drives only while a read strobe is low, else a changed word
   always_comb data_in = (mem_read_strobe_n && io_read_strobe_n) ? ~mem[idx] : mem[idx];
endmodule

// *** test/testbench.sv ***
`timescale 1ns/1ps
module testbench;
   logic clk_sys = 1'b0;
   logic resetn = 1'b0;
   logic reset_in_n = 1'b0;
   logic req_valid = 1'b0;
   logic [2:0] req_kind = 3'h0;
   logic [15:0] req_addr = 16'h0;
   logic [15:0] req_wdata = 16'h0;
   logic req_ready, rsp_valid, run, processor_clock_out, data_oe_n;
   logic mem_read_strobe_n, mem_write_strobe_n, io_read_strobe_n, io_write_strobe_n;
   logic [15:0] rsp_rdata, address_outputs, program_counter, data_in, data_out;
   int fail_count = 0;
   int cmp_count = 0;
   // Clock
   always #5 clk_sys = ~clk_sys;
   dsp_ext_bus_reset_control u_dsp_ext_bus_reset_control (
      .clk_sys(clk_sys),
      .resetn(resetn),
      .reset_in_n(reset_in_n),
      .req_valid(req_valid),
      .req_ready(req_ready),
      .req_kind(req_kind),
      .req_addr(req_addr),
      .req_wdata(req_wdata),
      .rsp_valid(rsp_valid),
      .rsp_rdata(rsp_rdata),
      .address_outputs(address_outputs),
      .program_counter(program_counter),
      .run(run),
      .processor_clock_out(processor_clock_out),
      .mem_read_strobe_n(mem_read_strobe_n),
      .mem_write_strobe_n(mem_write_strobe_n),
      .io_read_strobe_n(io_read_strobe_n),
      .io_write_strobe_n(io_write_strobe_n),
      .data_in(data_in),
      .data_out(data_out),
      .data_oe_n(data_oe_n)
   );
   sram_partner u_sram_partner (
      .clk_sys(clk_sys),
      .mem_read_strobe_n(mem_read_strobe_n),
      .mem_write_strobe_n(mem_write_strobe_n),
      .io_read_strobe_n(io_read_strobe_n),
      .io_write_strobe_n(io_write_strobe_n),
      .address_outputs(address_outputs),
      .data_out(data_out),
      .data_oe_n(data_oe_n),
      .data_in(data_in)
   );
   // Compare and count
   task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
      cmp_count++;
      if (got !== exp) begin
         fail_count++;
         $display("mismatch %s expected %h seen %h", name, exp, got);
      end
   endtask
   task automatic finish_test;
      $display("compares %0d mismatches %0d", cmp_count, fail_count);
      if (fail_count == 0 && cmp_count > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   // Bounded wait for execution to restart
   task automatic wait_run;
      int n;
      logic clk_seen;
      n = 0;
      while (run !== 1'b1 && n < 4) begin
         @(negedge clk_sys);
         n++;
      end
      chk("run", 16'h1, {15'h0, run});
      clk_seen = processor_clock_out;
      @(negedge clk_sys);
      chk("clock out", {15'h0, ~clk_seen}, {15'h0, processor_clock_out});
   endtask
   // One access: hold the request until taken, then wait for the answer
   task automatic acc(input logic [2:0] k, input logic [15:0] a, input logic [15:0] d);
      int n;
      n = 0;
      @(negedge clk_sys);
      req_valid = 1'b1;
      req_kind = k;
      req_addr = a;
      req_wdata = d;
      while (req_ready !== 1'b1 && n < 20) begin
         @(negedge clk_sys);
         n++;
      end
      @(negedge clk_sys);
      req_valid = 1'b0;
      while (rsp_valid !== 1'b1 && n < 40) begin
         @(negedge clk_sys);
         n++;
      end
      chk("done", 16'h1, {15'h0, rsp_valid});
   endtask
   // All four kinds back to back, same address in both spaces
   task automatic t_kinds;
      acc(3'h1, 16'h0003, 16'ha5c3);
      acc(3'h3, 16'h0003, 16'h5a3c);
      acc(3'h0, 16'h0003, 16'h0);
      chk("mem read", 16'ha5c3, rsp_rdata);
      chk("pc step", 16'h1, program_counter);
      acc(3'h2, 16'h0003, 16'h0);
      chk("io read", 16'h5a3c, rsp_rdata);
   endtask
   // Reset pin held five cycles while idle
   task automatic t_reset;
      @(negedge clk_sys);
      reset_in_n = 1'b0;
      repeat (5) @(negedge clk_sys);
      chk("strobes", 16'hf, {12'h0, mem_read_strobe_n, mem_write_strobe_n, io_read_strobe_n, io_write_strobe_n});
      chk("float", 16'h1, {15'h0, data_oe_n});
      chk("address", 16'h0, address_outputs);
      chk("pc", 16'h0, program_counter);
      reset_in_n = 1'b1;
      wait_run();
   endtask
   // Reset lands in a write; the bus must recover fully
   task automatic t_abort;
      @(negedge clk_sys);
      req_valid = 1'b1;
      req_kind = 3'h1;
      req_addr = 16'h0005;
      req_wdata = 16'h1234;
      @(negedge clk_sys);
      req_valid = 1'b0;
      reset_in_n = 1'b0;
      repeat (5) @(negedge clk_sys);
      chk("abort", 16'h1, {15'h0, data_oe_n});
      reset_in_n = 1'b1;
      wait_run();
      t_kinds();
   endtask
   initial begin
      repeat (12) @(negedge clk_sys);
      resetn = 1'b1;
      reset_in_n = 1'b1;
      wait_run();
      t_kinds();
      t_reset();
      t_abort();
      finish_test();
   end
   // Watchdog
   initial begin
      #20000;
      fail_count++;
      finish_test();
   end
endmodule
